// [nca_unit.sv]
// top of the negate/complement/idle-sync execution unit
//
`timescale 1ns/1ps
`default_nettype none
module nca_unit (
	input wire logic I_SYS_CLK,
	input wire logic I_SYS_RST,
	input wire logic I_OP_VALID,
	input wire logic [15:0] I_OP_WORD,
	input wire logic [31:0] I_OPERAND,
	input wire nca_pkg::nca_ccr_type I_CCR,
	input wire logic I_BUS_PENDING,
	output logic O_OP_READY,
	output logic O_DONE,
	output logic O_ILLEGAL,
	output logic O_WRITE_BACK,
	output logic [31:0] O_RESULT,
	output logic O_CCR_WE,
	output nca_pkg::nca_ccr_type O_CCR,
	output logic O_PC_ADVANCE,
	output logic [1:0] O_SIZE,
	output logic [2:0] O_EA_MODE,
	output logic [2:0] O_EA_REG
);
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_EXEC,
		ST_SYNC
	} nca_state_type;

	nca_state_type state;
	nca_state_type next_state;
	nca_pkg::nca_decode_type dec_now;
	nca_pkg::nca_decode_type lat_dec;
	logic [31:0] lat_operand;
	nca_pkg::nca_ccr_type lat_ccr;
	logic [31:0] alu_result;
	nca_pkg::nca_ccr_type alu_ccr;
	logic accept;
	logic finish;
	logic is_alu;

	// decode straight off the incoming word; only latched on accept
	nca_decode u_decode (
		.i_word(I_OP_WORD),
		.o_dec(dec_now)
	);

	// arithmetic works on latched values so the inputs may move after accept
	nca_arith u_arith (
		.i_op(lat_dec.op),
		.i_size(lat_dec.size),
		.i_operand(lat_operand),
		.i_ccr(lat_ccr),
		.o_result(alu_result),
		.o_ccr(alu_ccr)
	);

	// handshake: one op in flight at a time
	assign O_OP_READY = (state == ST_IDLE);
	assign accept = I_OP_VALID && O_OP_READY;
	assign is_alu = lat_dec.legal && (lat_dec.op != nca_pkg::OP_IDLE_SYNC);

	// completion: the idle op holds off while any bus cycle is outstanding
	always_comb begin
		finish = 1'b0;
		case (state)
			ST_EXEC: finish = !(lat_dec.op == nca_pkg::OP_IDLE_SYNC && I_BUS_PENDING);
			ST_SYNC: finish = !I_BUS_PENDING;
			default: finish = 1'b0;
		endcase
	end

	// sequencing
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (accept) begin
					next_state = ST_EXEC;
				end
			end
			ST_EXEC: begin
				next_state = finish ? ST_IDLE : ST_SYNC;
			end
			ST_SYNC: begin
				if (finish) begin
					next_state = ST_IDLE;
				end
			end
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge I_SYS_CLK) begin
		if (I_SYS_RST) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// capture of the instruction, destination value and incoming flags
	always_ff @(posedge I_SYS_CLK) begin
		if (I_SYS_RST) begin
			lat_dec <= '0;
			lat_operand <= 32'h0;
			lat_ccr <= '0;
		end else if (accept) begin
			lat_dec <= dec_now;
			lat_operand <= I_OPERAND;
			lat_ccr <= I_CCR;
		end
	end

	// completion strobe and status, one cycle per finished op
	always_ff @(posedge I_SYS_CLK) begin
		if (I_SYS_RST) begin
			O_DONE <= 1'b0;
			O_ILLEGAL <= 1'b0;
			O_PC_ADVANCE <= 1'b0;
		end else begin
			O_DONE <= finish;
			O_ILLEGAL <= finish && !lat_dec.legal;
			O_PC_ADVANCE <= finish && lat_dec.legal;
		end
	end

	// write-back: only arithmetic ops store a result or touch the flags
	always_ff @(posedge I_SYS_CLK) begin
		if (I_SYS_RST) begin
			O_WRITE_BACK <= 1'b0;
			O_CCR_WE <= 1'b0;
		end else begin
			O_WRITE_BACK <= finish && is_alu;
			O_CCR_WE <= finish && is_alu;
		end
	end

	// data outputs hold their last value between ops; flags pass through on idle op
	always_ff @(posedge I_SYS_CLK) begin
		if (I_SYS_RST) begin
			O_RESULT <= 32'h0;
			O_CCR <= '0;
			O_SIZE <= nca_pkg::SIZE_BYTE;
			O_EA_MODE <= nca_pkg::MODE_DATA_REG;
			O_EA_REG <= 3'h0;
		end else if (finish) begin
			O_RESULT <= is_alu ? alu_result : lat_operand;
			O_CCR <= is_alu ? alu_ccr : lat_ccr;
			O_SIZE <= lat_dec.size;
			O_EA_MODE <= lat_dec.ea_mode;
			O_EA_REG <= lat_dec.ea_reg;
		end
	end

	// checking helpers: sized views of the latched operand and the result
	logic [31:0] chk_mask;
	logic [31:0] chk_opd;
	logic chk_neg;
	logic [7:0] sync_wait;

	assign chk_mask = nca_pkg::size_mask(lat_dec.size);
	assign chk_opd = lat_operand & chk_mask;
	assign chk_neg = (lat_dec.op == nca_pkg::OP_ZERO_MINUS) ||
		(lat_dec.op == nca_pkg::OP_ZERO_MINUS_BORROW);

	// counts cycles spent waiting on the bus, saturating
	always_ff @(posedge I_SYS_CLK) begin
		if (I_SYS_RST) begin
			sync_wait <= 8'h0;
		end else if (state == ST_SYNC && I_BUS_PENDING) begin
			sync_wait <= (sync_wait == 8'hFF) ? sync_wait : sync_wait + 8'h01;
		end else begin
			sync_wait <= 8'h0;
		end
	end

	a_neg_result: assert property (
		@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
		(O_WRITE_BACK && lat_dec.op == nca_pkg::OP_ZERO_MINUS)
		|-> (O_RESULT == ((32'h0 - chk_opd) & chk_mask))
	) else $error("negate result is not zero minus operand");

	a_zero_minus_with_borrow_result: assert property (
		@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
		(O_WRITE_BACK && lat_dec.op == nca_pkg::OP_ZERO_MINUS_BORROW)
		|-> (O_RESULT == ((32'h0 - chk_opd - {31'h0, lat_ccr.x}) & chk_mask))
	) else $error("negate with extend result wrong");

	a_extend_carry: assert property (
		@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
		(O_CCR_WE && chk_neg) |-> (O_CCR.x == O_CCR.c)
	) else $error("extend flag differs from carry after negate");

	a_sign_flag: assert property (
		@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
		O_CCR_WE |-> (O_CCR.n == nca_pkg::size_msb(O_RESULT, O_SIZE))
	) else $error("sign flag does not follow result msb");

	a_zero_flag: assert property (
		@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
		O_CCR_WE |-> (O_CCR.z == ((O_RESULT & chk_mask) == 32'h0))
	) else $error("zero flag does not match sized result");

	a_neg_overflow: assert property (
		@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
		(O_CCR_WE && chk_neg)
		|-> (O_CCR.v == (nca_pkg::size_msb(chk_opd, lat_dec.size)
			&& nca_pkg::size_msb(O_RESULT, lat_dec.size)))
	) else $error("overflow flag wrong after negate");

	a_neg_carry: assert property (
		@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
		(O_CCR_WE && chk_neg) |-> (O_CCR.c == (O_RESULT != 32'h0))
	) else $error("carry flag wrong after negate");

	a_comp_flags: assert property (
		@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
		(O_CCR_WE && lat_dec.op == nca_pkg::OP_COMPLEMENT)
		|-> (!O_CCR.v && !O_CCR.c && O_CCR.x == lat_ccr.x
			&& O_RESULT == (~chk_opd & chk_mask))
	) else $error("complement result or flags wrong");

	a_size_bound: assert property (
		@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
		O_WRITE_BACK |-> ((O_RESULT & ~chk_mask) == 32'h0 && O_SIZE != 2'h3)
	) else $error("result exceeds its operation size");

	a_ea_reject: assert property (
		@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
		(O_DONE && lat_dec.op != nca_pkg::OP_IDLE_SYNC
			&& (lat_dec.ea_mode == nca_pkg::MODE_ADDR_REG
			|| (lat_dec.ea_mode == nca_pkg::MODE_EXTENDED && lat_dec.ea_reg[2:1] != 2'h0)))
		|-> (O_ILLEGAL && !O_WRITE_BACK && !O_PC_ADVANCE)
	) else $error("non-alterable destination was accepted");

	a_idle_state: assert property (
		@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
		(O_DONE && lat_dec.op == nca_pkg::OP_IDLE_SYNC)
		|-> (O_PC_ADVANCE && !O_WRITE_BACK && !O_CCR_WE && O_CCR == lat_ccr)
	) else $error("idle op changed processor state");

	a_idle_hold: assert property (
		@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
		(state == ST_SYNC && I_BUS_PENDING) |=> (!O_DONE && state == ST_SYNC)
	) else $error("idle op finished with a bus cycle pending");

	a_idle_release: assert property (
		@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
		(state == ST_SYNC && !I_BUS_PENDING) |=> (O_DONE ##1 !O_DONE)
	) else $error("idle op not released one cycle after bus idle");

	a_sync_count: assert property (
		@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
		(sync_wait != 8'h0) |-> $past(I_BUS_PENDING)
	) else $error("sync wait kept without a pending bus cycle");

	a_idle_decode: assert property (
		@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
		(accept && I_OP_WORD == nca_pkg::OPC_IDLE_SYNC)
		|=> (lat_dec.op == nca_pkg::OP_IDLE_SYNC && lat_dec.legal)
	) else $error("idle op word not recognised");

	a_alu_latency: assert property (
		@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
		(accept && dec_now.op != nca_pkg::OP_IDLE_SYNC) |=> ##1 O_DONE
	) else $error("arithmetic op did not finish in two cycles");

	// the reserved-size and mode-accept checks below restate the rules from the raw word, not from the decoder
	a_done_single: assert property (
		@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
		O_DONE |=> !O_DONE
	) else $error("completion strobe longer than one cycle");

	a_pc_legal: assert property (
		@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
		O_PC_ADVANCE |-> (O_DONE && !O_ILLEGAL)
	) else $error("program counter advanced outside a legal completion");

	a_wb_with_done: assert property (
		@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
		O_WRITE_BACK |-> (O_DONE && O_CCR_WE)
	) else $error("write-back without completion or flag update");

	a_ill_quiet: assert property (
		@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
		O_ILLEGAL |-> (O_DONE && !O_CCR_WE && !O_PC_ADVANCE)
	) else $error("rejected op changed state");

	a_size_reserved: assert property (
		@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
		(accept && I_OP_WORD != nca_pkg::OPC_IDLE_SYNC && I_OP_WORD[7:6] == 2'h3)
		|=> ##1 (O_ILLEGAL && !O_WRITE_BACK)
	) else $error("reserved size field was executed");

	// a legal destination must always be written; guards against an over-strict decoder
	a_mode_accept: assert property (
		@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
		(accept && (I_OP_WORD[15:8] == nca_pkg::OPC_ZERO_MINUS
			|| I_OP_WORD[15:8] == nca_pkg::OPC_ZERO_MINUS_BORROW
			|| I_OP_WORD[15:8] == nca_pkg::OPC_COMPLEMENT)
			&& I_OP_WORD[7:6] != 2'h3 && I_OP_WORD[5:3] != nca_pkg::MODE_ADDR_REG
			&& (I_OP_WORD[5:3] != nca_pkg::MODE_EXTENDED || I_OP_WORD[2:1] == 2'h0))
		|=> ##1 (O_WRITE_BACK && O_CCR_WE && O_PC_ADVANCE)
	) else $error("data-alterable destination was rejected");

	a_byte_msb: assert property (
		@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
		(O_CCR_WE && O_SIZE == nca_pkg::SIZE_BYTE) |-> (O_CCR.n == O_RESULT[7])
	) else $error("sign flag wrong for a byte result");

	a_long_msb: assert property (
		@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
		(O_CCR_WE && O_SIZE == nca_pkg::SIZE_LONG) |-> (O_CCR.n == O_RESULT[31])
	) else $error("sign flag wrong for a long result");

	a_word_high: assert property (
		@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
		(O_WRITE_BACK && O_SIZE == nca_pkg::SIZE_WORD) |-> (O_RESULT[31:16] == 16'h0)
	) else $error("word result has upper bits set");

	a_neg_zero: assert property (
		@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
		(O_CCR_WE && chk_neg && O_RESULT == 32'h0) |-> (O_CCR.z && !O_CCR.c && !O_CCR.x)
	) else $error("zero negate result left carry or extend set");

	// plain negate overflows only on the most negative value of the size
	a_neg_min: assert property (
		@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
		(O_CCR_WE && lat_dec.op == nca_pkg::OP_ZERO_MINUS)
		|-> (O_CCR.v == (chk_opd == (chk_mask & ~(chk_mask >> 1))))
	) else $error("negate overflow not tied to the most negative operand");

	a_zero_minus_with_borrow_no_ovf: assert property (
		@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
		(O_CCR_WE && lat_dec.op == nca_pkg::OP_ZERO_MINUS_BORROW && lat_ccr.x) |-> !O_CCR.v
	) else $error("negate with extend set reported overflow");

	a_sync_only_idle: assert property (
		@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
		(state == ST_SYNC) |-> (lat_dec.op == nca_pkg::OP_IDLE_SYNC)
	) else $error("arithmetic op waited on the bus");

	a_decode_hold: assert property (
		@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
		(state != ST_IDLE) |=> $stable(lat_dec)
	) else $error("latched instruction changed while busy");
endmodule : nca_unit
`default_nettype wire

// [nca_pkg.sv]
// package: opcodes, field layout, decode and flag types for the negate/complement unit
// Function
// - negate writes zero minus the sized destination back to the destination.
// - negate with extend writes zero minus destination minus extend back.
// - both negates load the extend flag with the carry flag value.
// - sign flag follows the result's most significant bit at the size.
// - zero flag is set when the sized result is zero, else cleared.
// - both negates set overflow on signed overflow of the subtraction.
// - both negates clear carry on zero result, set it otherwise.
// - complement inverts the operand, clears overflow and carry, keeps extend.
// - size field 00 byte, 01 word, 10 long.
// - destination only data-alterable: modes 000, 010-110, 111 with reg 000/001.
// - idle op only advances the program counter, all flags unchanged.
// - idle op waits until every outstanding bus cycle has completed.
package nca_pkg;
	localparam logic [7:0] OPC_ZERO_MINUS = 8'h44;
	localparam logic [7:0] OPC_ZERO_MINUS_BORROW = 8'h40;
	localparam logic [7:0] OPC_COMPLEMENT = 8'h46;
	localparam logic [15:0] OPC_IDLE_SYNC = 16'h4E71;
	localparam int OPC_HI_MSB = 15;
	localparam int OPC_HI_LSB = 8;
	localparam int SIZE_MSB = 7;
	localparam int SIZE_LSB = 6;
	localparam int MODE_MSB = 5;
	localparam int MODE_LSB = 3;
	localparam int EAREG_MSB = 2;
	localparam int EAREG_LSB = 0;
	localparam logic [1:0] SIZE_BYTE = 2'h0;
	localparam logic [1:0] SIZE_WORD = 2'h1;
	localparam logic [1:0] SIZE_LONG = 2'h2;
	localparam logic [2:0] MODE_DATA_REG = 3'h0;
	localparam logic [2:0] MODE_ADDR_REG = 3'h1;
	localparam logic [2:0] MODE_EXTENDED = 3'h7;
	localparam logic [2:0] EXT_ABS_SHORT = 3'h0;
	localparam logic [2:0] EXT_ABS_LONG = 3'h1;
	localparam logic [31:0] MASK_BYTE = 32'h000000FF;
	localparam logic [31:0] MASK_WORD = 32'h0000FFFF;
	localparam logic [31:0] MASK_LONG = 32'hFFFFFFFF;

	typedef enum logic [2:0] {
		OP_NONE,
		OP_ZERO_MINUS,
		OP_ZERO_MINUS_BORROW,
		OP_COMPLEMENT,
		OP_IDLE_SYNC
	} nca_op_type;

	typedef struct packed {
		nca_op_type op;
		logic [1:0] size;
		logic [2:0] ea_mode;
		logic [2:0] ea_reg;
		logic legal;
	} nca_decode_type;

	typedef struct packed {
		logic x;
		logic n;
		logic z;
		logic v;
		logic c;
	} nca_ccr_type;

	// keeps only the bits that belong to the operation size
	function automatic logic [31:0] size_mask(input logic [1:0] size);
		case (size)
			SIZE_BYTE: size_mask = MASK_BYTE;
			SIZE_WORD: size_mask = MASK_WORD;
			default: size_mask = MASK_LONG;
		endcase
	endfunction : size_mask

	// most significant bit at the operation size
	function automatic logic size_msb(input logic [31:0] value, input logic [1:0] size);
		case (size)
			SIZE_BYTE: size_msb = value[7];
			SIZE_WORD: size_msb = value[15];
			default: size_msb = value[31];
		endcase
	endfunction : size_msb
endpackage : nca_pkg

// [nca_decode.sv]
// instruction word decoder for the negate/complement/idle group
`timescale 1ns/1ps
`default_nettype none
module nca_decode (
	input wire logic [15:0] i_word,
	output nca_pkg::nca_decode_type o_dec
);
	logic [7:0] hi;
	logic alterable;
	logic size_ok;

	// mode 001 and 111 with reg above 001 are not writable data locations
	always_comb begin
		hi = i_word[nca_pkg::OPC_HI_MSB:nca_pkg::OPC_HI_LSB];
		o_dec.size = i_word[nca_pkg::SIZE_MSB:nca_pkg::SIZE_LSB];
		o_dec.ea_mode = i_word[nca_pkg::MODE_MSB:nca_pkg::MODE_LSB];
		o_dec.ea_reg = i_word[nca_pkg::EAREG_MSB:nca_pkg::EAREG_LSB];
		alterable = (o_dec.ea_mode != nca_pkg::MODE_ADDR_REG) &&
			((o_dec.ea_mode != nca_pkg::MODE_EXTENDED) ||
			(o_dec.ea_reg == nca_pkg::EXT_ABS_SHORT) ||
			(o_dec.ea_reg == nca_pkg::EXT_ABS_LONG));
		size_ok = (o_dec.size != 2'h3);
		o_dec.op = nca_pkg::OP_NONE;
		if (i_word == nca_pkg::OPC_IDLE_SYNC) begin
			o_dec.op = nca_pkg::OP_IDLE_SYNC;
		end else if (hi == nca_pkg::OPC_ZERO_MINUS) begin
			o_dec.op = nca_pkg::OP_ZERO_MINUS;
		end else if (hi == nca_pkg::OPC_ZERO_MINUS_BORROW) begin
			o_dec.op = nca_pkg::OP_ZERO_MINUS_BORROW;
		end else if (hi == nca_pkg::OPC_COMPLEMENT) begin
			o_dec.op = nca_pkg::OP_COMPLEMENT;
		end
		if (o_dec.op == nca_pkg::OP_IDLE_SYNC) begin
			o_dec.legal = 1'b1;
		end else begin
			o_dec.legal = (o_dec.op != nca_pkg::OP_NONE) && alterable && size_ok;
		end
	end
endmodule : nca_decode
`default_nettype wire

// [nca_arith.sv]
// sized result and flag computation for negate and complement
`timescale 1ns/1ps
`default_nettype none
module nca_arith (
	input wire nca_pkg::nca_op_type i_op,
	input wire logic [1:0] i_size,
	input wire logic [31:0] i_operand,
	input wire nca_pkg::nca_ccr_type i_ccr,
	output logic [31:0] o_result,
	output nca_pkg::nca_ccr_type o_ccr
);
	logic [31:0] mask;
	logic [31:0] opd;
	logic borrow_in;
	logic d_msb;

	// all arithmetic is done at 32 bits and trimmed, so one adder serves every size
	always_comb begin
		mask = nca_pkg::size_mask(i_size);
		opd = i_operand & mask;
		d_msb = nca_pkg::size_msb(opd, i_size);
		borrow_in = (i_op == nca_pkg::OP_ZERO_MINUS_BORROW) ? i_ccr.x : 1'b0;
		o_ccr = i_ccr;
		if (i_op == nca_pkg::OP_COMPLEMENT) begin
			o_result = ~opd & mask;
			o_ccr.v = 1'b0;
			o_ccr.c = 1'b0;
		end else begin
			o_result = (32'h0 - opd - {31'h0, borrow_in}) & mask;
			o_ccr.v = d_msb & nca_pkg::size_msb(o_result, i_size);
			o_ccr.c = (o_result != 32'h0);
			o_ccr.x = o_ccr.c;
		end
		o_ccr.n = nca_pkg::size_msb(o_result, i_size);
		o_ccr.z = (o_result == 32'h0);
	end
endmodule : nca_arith
`default_nettype wire

// [tb.sv]
// self-checking bench for the negate/complement/idle-sync unit
`timescale 1ns/1ps
`default_nettype none
module tb;
	typedef struct packed {
		logic idle;
		logic ill;
		logic [31:0] res;
		nca_pkg::nca_ccr_type ccr;
		logic [1:0] size;
		logic [2:0] mode;
		logic [2:0] rg;
	} nca_exp_type;

	logic I_SYS_CLK;
	logic I_SYS_RST;
	logic I_OP_VALID;
	logic [15:0] I_OP_WORD;
	logic [31:0] I_OPERAND;
	nca_pkg::nca_ccr_type I_CCR;
	logic I_BUS_PENDING;
	logic O_OP_READY, O_DONE, O_ILLEGAL, O_WRITE_BACK, O_CCR_WE, O_PC_ADVANCE;
	logic [31:0] O_RESULT;
	nca_pkg::nca_ccr_type O_CCR;
	logic [1:0] O_SIZE;
	logic [2:0] O_EA_MODE, O_EA_REG;
	int n_errors = 0;
	int check_count = 0;
	integer seed = 32'h6412;
	nca_exp_type exp_q[$];
	nca_exp_type e;
	logic prev_pend;

	nca_unit dut_u (.I_SYS_CLK(I_SYS_CLK), .I_SYS_RST(I_SYS_RST), .I_OP_VALID(I_OP_VALID),
		.I_OP_WORD(I_OP_WORD), .I_OPERAND(I_OPERAND), .I_CCR(I_CCR),
		.I_BUS_PENDING(I_BUS_PENDING), .O_OP_READY(O_OP_READY), .O_DONE(O_DONE),
		.O_ILLEGAL(O_ILLEGAL), .O_WRITE_BACK(O_WRITE_BACK), .O_RESULT(O_RESULT),
		.O_CCR_WE(O_CCR_WE), .O_CCR(O_CCR), .O_PC_ADVANCE(O_PC_ADVANCE), .O_SIZE(O_SIZE),
		.O_EA_MODE(O_EA_MODE), .O_EA_REG(O_EA_REG));

	// 50 MHz core clock
	initial begin
		I_SYS_CLK = 1'b0;
		forever #10 I_SYS_CLK = ~I_SYS_CLK;
	end

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task automatic results();
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : results

	// reference model kept independent of the package helpers on purpose
	function automatic nca_exp_type model(input logic [15:0] w, input logic [31:0] d,
		input nca_pkg::nca_ccr_type f);
		nca_exp_type r;
		logic [31:0] m;
		logic [31:0] o;
		logic [31:0] top;
		logic [7:0] hi;
		r = '0;
		hi = w[15:8];
		r.size = w[7:6];
		r.mode = w[5:3];
		r.rg = w[2:0];
		r.ccr = f;
		if (w == nca_pkg::OPC_IDLE_SYNC) begin
			r.idle = 1'b1;
			return r;
		end
		r.ill = !(hi == nca_pkg::OPC_ZERO_MINUS || hi == nca_pkg::OPC_ZERO_MINUS_BORROW
			|| hi == nca_pkg::OPC_COMPLEMENT) || r.size == 2'h3 || r.mode == 3'h1
			|| (r.mode == 3'h7 && r.rg > 3'h1);
		if (r.ill) return r;
		m = (r.size == 2'h0) ? 32'h000000FF : (r.size == 2'h1) ? 32'h0000FFFF : 32'hFFFFFFFF;
		top = m & ~(m >> 1);
		o = d & m;
		if (hi == nca_pkg::OPC_COMPLEMENT) begin
			r.res = ~o & m;
			r.ccr.v = 1'b0;
			r.ccr.c = 1'b0;
		end else begin
			r.res = (32'h0 - o - ((hi == nca_pkg::OPC_ZERO_MINUS_BORROW) ? {31'h0, f.x} : 32'h0)) & m;
			r.ccr.c = |r.res;
			r.ccr.x = |r.res;
			r.ccr.v = |(o & top) && |(r.res & top);
		end
		r.ccr.n = |(r.res & top);
		r.ccr.z = (r.res == 32'h0);
		return r;
	endfunction : model

	// one op: drive with valid for one clock, drop valid, then wait for completion
	task automatic issue(input logic [15:0] w, input logic [31:0] d,
		input nca_pkg::nca_ccr_type f, input int pend);
		int k;
		exp_q.push_back(model(w, d, f));
		@(posedge I_SYS_CLK);
		I_OP_VALID <= 1'b1;
		I_OP_WORD <= w;
		I_OPERAND <= d;
		I_CCR <= f;
		I_BUS_PENDING <= (pend > 0);
		@(posedge I_SYS_CLK);
		I_OP_VALID <= 1'b0;
		// scramble inputs so a late sample of them shows up
		I_OP_WORD <= ~w;
		I_OPERAND <= ~d;
		I_CCR <= ~f;
		k = 0;
		while (O_DONE !== 1'b1 && k < 60) begin
			@(posedge I_SYS_CLK);
			k++;
			if (k == pend) I_BUS_PENDING <= 1'b0;
		end
		if (k >= 60) begin
			check("done timeout", 32'h0, 32'h1);
			results();
		end
		if (pend > 0) begin
			check("idle wait length", 32'(k), 32'(pend + 2));
		end else begin
			check("op latency", 32'(k), 32'h2);
		end
	endtask : issue

	always @(posedge I_SYS_CLK) prev_pend <= I_BUS_PENDING;

	// result watcher: each completion consumes the oldest expectation
	always @(posedge I_SYS_CLK) begin
		if (O_DONE === 1'b1) begin
			if (exp_q.size() == 0) begin
				check("unexpected done", 32'h1, 32'h0);
			end else begin
				e = exp_q.pop_front();
				check("illegal", O_ILLEGAL, e.ill);
				check("pc advance", O_PC_ADVANCE, !e.ill);
				check("write back", O_WRITE_BACK, !e.ill && !e.idle);
				check("flag write", O_CCR_WE, !e.ill && !e.idle);
				if (e.idle) begin
					check("idle flags", O_CCR, e.ccr);
					check("pending before done", prev_pend, 1'b0);
				end else if (!e.ill) begin
					check("result", O_RESULT, e.res);
					check("x flag", O_CCR.x, e.ccr.x);
					check("n flag", O_CCR.n, e.ccr.n);
					check("z flag", O_CCR.z, e.ccr.z);
					check("v flag", O_CCR.v, e.ccr.v);
					check("c flag", O_CCR.c, e.ccr.c);
					check("size", O_SIZE, e.size);
					check("ea mode", O_EA_MODE, e.mode);
					check("ea reg", O_EA_REG, e.rg);
				end
			end
		end
	end

	initial begin
		static logic [31:0] corner[8] = '{32'h0, 32'h1, 32'h80, 32'h7F, 32'h8000, 32'hFF,
			32'h80000000, 32'hFFFFFFFF};
		static logic [7:0] ops[3] = '{nca_pkg::OPC_ZERO_MINUS, nca_pkg::OPC_ZERO_MINUS_BORROW,
			nca_pkg::OPC_COMPLEMENT};
		logic [31:0] r;
		I_SYS_RST = 1'b1;
		I_OP_VALID = 1'b0;
		I_OP_WORD = 16'h0;
		I_OPERAND = 32'h0;
		I_CCR = '0;
		I_BUS_PENDING = 1'b0;
		repeat (2) @(posedge I_SYS_CLK);
		I_SYS_RST <= 1'b0;
		// every arithmetic op, size and boundary operand, extend both ways
		for (int o = 0; o < 3; o++) begin
			for (int s = 0; s < 3; s++) begin
				for (int c = 0; c < 16; c++) begin
					r = $random(seed);
					// zero flag preset as software does ahead of a chained negate
					issue({ops[o], s[1:0], 3'h0, r[2:0]}, corner[c % 8],
						nca_pkg::nca_ccr_type'({c[3], 4'h4}), 0);
				end
			end
		end
		$display("test corners done");
		// every destination mode and register, plus the reserved size
		for (int a = 0; a < 64; a++) begin
			r = $random(seed);
			issue({ops[a % 3], 2'h1, a[5:0]}, r, nca_pkg::nca_ccr_type'(r[4:0]), 0);
		end
		issue({nca_pkg::OPC_ZERO_MINUS, 8'hC0}, 32'h5, '0, 0);
		issue(16'h4E70, 32'h5, '0, 0);
		issue(16'h4E72, 32'h5, '0, 0);
		$display("test modes done");
		// idle op with bus cycles still in flight
		for (int p = 0; p < 6; p++) begin
			r = $random(seed);
			issue(nca_pkg::OPC_IDLE_SYNC, r, nca_pkg::nca_ccr_type'(r[4:0]), p);
		end
		$display("test idle done");
		// random mix of all ops, idle and stray words
		for (int i = 0; i < 300; i++) begin
			r = $random(seed);
			case (r[31:30])
				2'h3: issue(nca_pkg::OPC_IDLE_SYNC, r, nca_pkg::nca_ccr_type'(r[4:0]),
					int'(r[9:8]));
				default: issue({(r[29] ? r[23:16] : ops[r[31:30]]), r[15:8]}, $random(seed),
					nca_pkg::nca_ccr_type'(r[4:0]), 0);
			endcase
		end
		$display("test random done");
		// reset in mid-run returns the unit to idle
		@(posedge I_SYS_CLK);
		I_SYS_RST <= 1'b1;
		@(posedge I_SYS_CLK);
		I_SYS_RST <= 1'b0;
		@(posedge I_SYS_CLK);
		check("ready after reset", O_OP_READY, 1'b1);
		check("done after reset", O_DONE, 1'b0);
		issue({nca_pkg::OPC_ZERO_MINUS_BORROW, 8'h80}, 32'h0, nca_pkg::nca_ccr_type'(5'h10), 0);
		$display("test reset done");
		results();
	end
endmodule : tb
`default_nettype wire
